// File: srs_top.sv
`timescale 1ns/10ps
module srs_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] op_0,
  input wire logic first_cp_0,
  input wire logic [2:0] reg_sel_0,
  input wire logic [4:0] sem_sel_0,
  input wire logic [63:0] wdata_0,
  input wire logic monitor_0,
  input wire logic xchg_clus_load_0,
  input wire logic [1:0] xchg_clus_0,
  input wire logic intr_req_0,
  input wire logic [23:0] tas_pc_0,
  input wire logic [3:0] op_1,
  input wire logic first_cp_1,
  input wire logic [2:0] reg_sel_1,
  input wire logic [4:0] sem_sel_1,
  input wire logic [63:0] wdata_1,
  input wire logic monitor_1,
  input wire logic xchg_clus_load_1,
  input wire logic [1:0] xchg_clus_1,
  input wire logic intr_req_1,
  input wire logic [23:0] tas_pc_1,
  output logic [1:0] issue_hold,
  output logic [1:0] issue_done,
  output logic [63:0] rdata_0,
  output logic [63:0] rdata_1,
  output logic [1:0] rvalid,
  output logic [1:0] deadlock_intr,
  output logic [1:0] discard_slots,
  output logic [23:0] restart_pc_0,
  output logic [23:0] restart_pc_1,
  output logic [1:0] semaphore_wait_flag,
  output logic [1:0] cluster_select_0,
  output logic [1:0] cluster_select_1,
  output logic [63:0] cycle_counter
);
  localparam logic [3:0] OP_TAS = 4'(srs_pkg::SRS_SEM_TAS);

  logic [3:0] op [2];
  logic [1:0] clus [2];
  logic [2:0] rsel [2];
  logic [4:0] ssel [2];
  logic [63:0] wd [2];
  logic [1:0] first;
  logic [1:0] is_rd, is_wr, is_sa, hold, go, tas_wait, sem_bit;
  logic [2:0] wr_hist [2];
  logic [31:0] sem_now [2];
  logic [31:0] sem_1, sem_2, sem_3;
  logic [31:0] clr_m [2];
  logic [31:0] set_m [2];
  logic [1:0] sem_ld;
  logic mem_sel, sa_we, ss_we;
  logic [4:0] mem_idx, rd_idx;
  logic [63:0] sa_q, ss_q;
  logic [1:0] rd_pend, rd_sa, rd_zero;

  assign op[0] = op_0;
  assign op[1] = op_1;
  assign clus[0] = cluster_select_0;
  assign clus[1] = cluster_select_1;
  assign rsel[0] = reg_sel_0;
  assign rsel[1] = reg_sel_1;
  assign ssel[0] = sem_sel_0;
  assign ssel[1] = sem_sel_1;
  assign wd[0] = wdata_0;
  assign wd[1] = wdata_1;
  assign first = {first_cp_1, first_cp_0};

  function automatic logic [31:0] pick_set(input logic [1:0] c, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] d);
    case (c)
      2'h1: pick_set = a;
      2'h2: pick_set = b;
      2'h3: pick_set = d;
      default: pick_set = 32'h0;
    endcase
  endfunction : pick_set

  // Semaphore index 0 sits in bit 31 so the bulk move lands it in bit 63
  function automatic logic [31:0] sem_mask(input logic [4:0] s);
    sem_mask = 32'h80000000 >> s;
  endfunction : sem_mask

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      is_rd[i] = (op[i] == 4'(srs_pkg::SRS_SA_READ)) || (op[i] == 4'(srs_pkg::SRS_SS_READ));
      is_wr[i] = (op[i] == 4'(srs_pkg::SRS_SA_WRITE)) || (op[i] == 4'(srs_pkg::SRS_SS_WRITE));
      is_sa[i] = (op[i] == 4'(srs_pkg::SRS_SA_READ)) || (op[i] == 4'(srs_pkg::SRS_SA_WRITE));
      sem_now[i] = pick_set(clus[i], sem_1, sem_2, sem_3);
      sem_bit[i] = |(sem_now[i] & sem_mask(ssel[i]));
    end
  end

  // Read and write conflict holds use activity only, never cluster selectors
  always_comb begin
    hold = 2'b00;
    if ((is_rd[0] && is_rd[1]) || (is_wr[0] && is_wr[1])) begin
      if (first[1]) hold[1] = 1'b1;
      else hold[0] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (is_rd[i] && (wr_hist[0][2] || wr_hist[1][2])) hold[i] = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      tas_wait[i] = 1'b0;
      if (op[i] == OP_TAS && clus[i] != srs_pkg::CLUS_NONE) begin
        if (sem_bit[i]) tas_wait[i] = 1'b1;
      end
    end
    // Same semaphore, same set, both free: processor 1 waits a cycle
    if (op[0] == OP_TAS && op[1] == OP_TAS && clus[0] == clus[1] &&
        clus[0] != srs_pkg::CLUS_NONE && ssel[0] == ssel[1] && !tas_wait[0]) begin
      tas_wait[1] = 1'b1;
    end
    hold = hold | tas_wait;
    go = ~hold & {op[1] != 4'(srs_pkg::SRS_NOP), op[0] != 4'(srs_pkg::SRS_NOP)};
  end

  // A read and a write may meet in one cycle, so each has its own index
  always_comb begin
    mem_sel = go[1] && is_wr[1];
    mem_idx = mem_sel ? {clus[1] - 2'h1, rsel[1]} : {clus[0] - 2'h1, rsel[0]};
    rd_idx = (go[1] && is_rd[1]) ? {clus[1] - 2'h1, rsel[1]} : {clus[0] - 2'h1, rsel[0]};
    sa_we = 1'b0;
    ss_we = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (go[i] && is_wr[i] && clus[i] != srs_pkg::CLUS_NONE) begin
        if (is_sa[i]) sa_we = 1'b1;
        else ss_we = 1'b1;
      end
    end
  end

  srs_shared_mem #(.W(64)) u_sa (
    .clk(clk),
    .we(sa_we),
    .waddr(mem_idx),
    .wdata({40'h0, wd[sa_we && go[1] && is_wr[1] ? 1 : 0][23:0]}),
    .raddr(rd_idx),
    .rdata(sa_q)
  );

  srs_shared_mem #(.W(64)) u_ss (
    .clk(clk),
    .we(ss_we),
    .waddr(mem_idx),
    .wdata(wd[ss_we && go[1] && is_wr[1] ? 1 : 0]),
    .raddr(rd_idx),
    .rdata(ss_q)
  );

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      clr_m[i] = 32'h0;
      set_m[i] = 32'h0;
      sem_ld[i] = 1'b0;
      if (go[i] && clus[i] != srs_pkg::CLUS_NONE) begin
        case (op[i])
          4'(srs_pkg::SRS_SEM_CLR): clr_m[i] = sem_mask(ssel[i]);
          4'(srs_pkg::SRS_SEM_SET): set_m[i] = sem_mask(ssel[i]);
          4'(srs_pkg::SRS_SEM_TAS): set_m[i] = sem_mask(ssel[i]);
          4'(srs_pkg::SRS_SEM_WRITE): sem_ld[i] = 1'b1;
          default: sem_ld[i] = 1'b0;
        endcase
      end
    end
  end

  srs_sem_bank u_sem (
    .clk(clk),
    .resetn(resetn),
    .set_a(clus[0]),
    .clr_a(clr_m[0]),
    .set_mask_a(set_m[0]),
    .load_a(sem_ld[0]),
    .load_val_a(wd[0][63:32]),
    .set_b(clus[1]),
    .clr_b(clr_m[1]),
    .set_mask_b(set_m[1]),
    .load_b(sem_ld[1]),
    .load_val_b(wd[1][63:32]),
    .sem_1(sem_1),
    .sem_2(sem_2),
    .sem_3(sem_3)
  );

  // Write history for the three-clock read-after-write hold
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_hist[0] <= 3'h0;
      wr_hist[1] <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        wr_hist[i] <= {wr_hist[i][1:0], go[i] && is_wr[i]};
      end
    end
  end

  // Cycle counter; processor 1 load wins when both load together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cycle_counter <= srs_pkg::CNT_RESET;
    end else if (op[1] == 4'(srs_pkg::SRS_CNT_LOAD)) begin
      cycle_counter <= wd[1];
    end else if (op[0] == 4'(srs_pkg::SRS_CNT_LOAD)) begin
      cycle_counter <= wd[0];
    end else begin
      cycle_counter <= cycle_counter + 64'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cluster_select_0 <= srs_pkg::CLUS_NONE;
      cluster_select_1 <= srs_pkg::CLUS_NONE;
    end else begin
      if (xchg_clus_load_0) cluster_select_0 <= xchg_clus_0;
      else if (op_0 == 4'(srs_pkg::SRS_CLUS_LOAD) && monitor_0) cluster_select_0 <= wdata_0[1:0];
      if (xchg_clus_load_1) cluster_select_1 <= xchg_clus_1;
      else if (op_1 == 4'(srs_pkg::SRS_CLUS_LOAD) && monitor_1) cluster_select_1 <= wdata_1[1:0];
    end
  end

  // Read returns: counter and semaphores direct, files one cycle later
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend <= 2'b00;
      rd_sa <= 2'b00;
      rd_zero <= 2'b00;
      rvalid <= 2'b00;
      rdata_0 <= 64'h0;
      rdata_1 <= 64'h0;
      issue_hold <= 2'b00;
      issue_done <= 2'b00;
    end else begin
      issue_hold <= hold;
      issue_done <= go;
      for (int i = 0; i < 2; i++) begin
        rd_pend[i] <= go[i] && is_rd[i];
        rd_sa[i] <= is_sa[i];
        rd_zero[i] <= clus[i] == srs_pkg::CLUS_NONE;
      end
      rvalid <= 2'b00;
      if (go[0] && op[0] == 4'(srs_pkg::SRS_CNT_READ)) begin
        rdata_0 <= cycle_counter;
        rvalid[0] <= 1'b1;
      end else if (go[0] && op[0] == 4'(srs_pkg::SRS_SEM_READ)) begin
        rdata_0 <= {sem_now[0], 32'h0};
        rvalid[0] <= 1'b1;
      end else if (rd_pend[0]) begin
        rdata_0 <= rd_zero[0] ? 64'h0 : (rd_sa[0] ? sa_q : ss_q);
        rvalid[0] <= 1'b1;
      end
      if (go[1] && op[1] == 4'(srs_pkg::SRS_CNT_READ)) begin
        rdata_1 <= cycle_counter;
        rvalid[1] <= 1'b1;
      end else if (go[1] && op[1] == 4'(srs_pkg::SRS_SEM_READ)) begin
        rdata_1 <= {sem_now[1], 32'h0};
        rvalid[1] <= 1'b1;
      end else if (rd_pend[1]) begin
        rdata_1 <= rd_zero[1] ? 64'h0 : (rd_sa[1] ? sa_q : ss_q);
        rvalid[1] <= 1'b1;
      end
    end
  end

  // Deadlock detection and the special exchange on a held test-and-set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      deadlock_intr <= 2'b00;
      discard_slots <= 2'b00;
      semaphore_wait_flag <= 2'b00;
      restart_pc_0 <= 24'h0;
      restart_pc_1 <= 24'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (clus[i] == srs_pkg::CLUS_NONE) begin
          deadlock_intr[i] <= 1'b0;
        end else if (clus[0] == clus[1]) begin
          deadlock_intr[i] <= tas_wait[0] && tas_wait[1];
        end else begin
          deadlock_intr[i] <= tas_wait[i];
        end
      end
      // Otherwise the pipeline drains normally before exchange
      discard_slots[0] <= intr_req_0 && tas_wait[0];
      discard_slots[1] <= intr_req_1 && tas_wait[1];
      semaphore_wait_flag[0] <= intr_req_0 && tas_wait[0];
      semaphore_wait_flag[1] <= intr_req_1 && tas_wait[1];
      if (intr_req_0 && tas_wait[0]) restart_pc_0 <= tas_pc_0;
      if (intr_req_1 && tas_wait[1]) restart_pc_1 <= tas_pc_1;
    end
  end

  a_tas_exclusive: assert property (@(posedge clk) disable iff (!resetn)
    !(go[0] && go[1] && op[0] == OP_TAS && op[1] == OP_TAS && clus[0] == clus[1]
      && ssel[0] == ssel[1])) else $error("both completed test-and-set");
  a_tas_held_set: assert property (@(posedge clk) disable iff (!resetn)
    (op[0] == OP_TAS && clus[0] != 2'h0 && sem_bit[0]) |-> !go[0])
    else $error("test-and-set issued on set semaphore");
  a_counter_step: assert property (@(posedge clk) disable iff (!resetn)
    (op[0] != 4'(srs_pkg::SRS_CNT_LOAD) && op[1] != 4'(srs_pkg::SRS_CNT_LOAD))
    |=> cycle_counter == $past(cycle_counter) + 64'h1) else $error("counter step");
  a_read_collide: assert property (@(posedge clk) disable iff (!resetn)
    (is_rd[0] && is_rd[1] && first[1]) |=> issue_hold[1]) else $error("p1 not held");
  a_raw_hold: assert property (@(posedge clk) disable iff (!resetn)
    (go[0] && is_wr[0]) ##3 is_rd[1] |-> hold[1]) else $error("raw hold missed");
  a_no_dl_zero: assert property (@(posedge clk) disable iff (!resetn)
    (clus[0] == 2'h0) |=> !deadlock_intr[0]) else $error("deadlock in cluster 0");
  a_dl_split: assert property (@(posedge clk) disable iff (!resetn)
    (clus[0] != clus[1] && clus[0] != 2'h0 && tas_wait[0]) |=> deadlock_intr[0])
    else $error("split cluster deadlock");
  a_wait_flag: assert property (@(posedge clk) disable iff (!resetn)
    (intr_req_1 && tas_wait[1]) |=> semaphore_wait_flag[1] && restart_pc_1 == $past(tas_pc_1))
    else $error("wait flag");
endmodule : srs_top

// File: srs_pkg.sv
package srs_pkg;
  localparam int ADDR_W = 24;
  localparam int WORD_W = 64;
  localparam int NUM_REGS = 8;
  localparam int NUM_SEM = 32;
  localparam int NUM_SETS = 3;
  localparam int SEL_W = 3;
  localparam int SEM_SEL_W = 5;
  localparam int CLUS_W = 2;
  localparam int WRITE_LAG = 3;
  localparam logic [1:0] CLUS_NONE = 2'h0;
  localparam logic [WORD_W-1:0] CNT_RESET = 64'h0;
  typedef enum logic [3:0] {
    SRS_NOP, SRS_CNT_LOAD, SRS_CNT_READ, SRS_SA_READ, SRS_SA_WRITE, SRS_SS_READ,
    SRS_SS_WRITE, SRS_SEM_TAS, SRS_SEM_CLR, SRS_SEM_SET, SRS_SEM_READ,
    SRS_SEM_WRITE, SRS_CLUS_LOAD
  } srs_op_t;
endpackage : srs_pkg

// File: srs_shared_mem.sv
`timescale 1ns/10ps
module srs_shared_mem #(
  parameter int W = 64
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [4:0] raddr,
  output logic [W-1:0] rdata
);
  // 3 sets x 8 words, index = (set-1)*8 + reg
  logic [W-1:0] mem [0:23];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : srs_shared_mem

// File: srs_sem_bank.sv
`timescale 1ns/10ps
module srs_sem_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [1:0] set_a,
  input wire logic [31:0] clr_a,
  input wire logic [31:0] set_mask_a,
  input wire logic load_a,
  input wire logic [31:0] load_val_a,
  input wire logic [1:0] set_b,
  input wire logic [31:0] clr_b,
  input wire logic [31:0] set_mask_b,
  input wire logic load_b,
  input wire logic [31:0] load_val_b,
  output logic [31:0] sem_1,
  output logic [31:0] sem_2,
  output logic [31:0] sem_3
);
  logic [31:0] sem [1:3];
  assign sem_1 = sem[1];
  assign sem_2 = sem[2];
  assign sem_3 = sem[3];
  // Processor 1 load wins over 0; sets win over clears
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int s = 1; s <= 3; s++) begin
        sem[s] <= 32'h0;
      end
    end else begin
      for (int s = 1; s <= 3; s++) begin
        logic [31:0] v;
        v = sem[s];
        if (load_a && set_a == s[1:0]) v = load_val_a;
        if (load_b && set_b == s[1:0]) v = load_val_b;
        if (set_a == s[1:0]) v = v & ~clr_a;
        if (set_b == s[1:0]) v = v & ~clr_b;
        if (set_a == s[1:0]) v = v | set_mask_a;
        if (set_b == s[1:0]) v = v | set_mask_b;
        sem[s] <= v;
      end
    end
  end
endmodule : srs_sem_bank

// File: srs_cpu_model.sv
`timescale 1ns/10ps
module srs_cpu_model (
  input wire logic clk,
  input wire logic done,
  input wire logic rv,
  input wire logic [63:0] rd,
  output srs_pkg::srs_op_t op,
  output logic first_cp,
  output logic [2:0] reg_sel,
  output logic [4:0] sem_sel,
  output logic [63:0] wdata
);
  initial begin
    op = srs_pkg::SRS_NOP;
    {first_cp, reg_sel, sem_sel, wdata} = '0;
  end
  // Held request stays put; gives up after lim holds with hc of -1
  task automatic run(input srs_pkg::srs_op_t o, input logic f, input logic [4:0] s,
      input logic [63:0] w, input int lim, output int hc, output logic [63:0] r);
    hc = 0;
    r = '0;
    op = o;
    {first_cp, reg_sel, sem_sel, wdata} = {f, s[2:0], s, w};
    @(posedge clk);
    #1;
    while (done !== 1'b1 && hc < lim) begin
      hc++;
      first_cp = 1'b0;
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) hc = -1;
    op = srs_pkg::SRS_NOP;
    // Fixed tail keeps any two requests over three clocks apart
    for (int i = 0; i < 4; i++) begin
      if (rv === 1'b1) r = rd;
      @(posedge clk);
      #1;
    end
  endtask : run
endmodule : srs_cpu_model

// File: srs_top_tb.sv
`timescale 1ns/10ps
module srs_top_tb;
  logic clk, resetn;
  logic [1:0] mon, xld, irq, xc0, xc1, hold, done, rv, dl, disc, wsf, cs0, cs1;
  logic [23:0] pc0, rpc0;
  srs_pkg::srs_op_t op0, op1, o;
  logic f0, f1;
  logic [2:0] rs0, rs1;
  logic [4:0] ss0, ss1, s, t;
  logic [63:0] wd0, wd1, rd0, rd1, cnt, r0, r1, v, c;
  int n_mismatch = 0;
  int checks = 0;
  int h0, h1;
  srs_top srs_top_inst (.clk(clk), .resetn(resetn),
    .op_0(op0), .first_cp_0(f0), .reg_sel_0(rs0), .sem_sel_0(ss0), .wdata_0(wd0),
    .monitor_0(mon[0]), .xchg_clus_load_0(xld[0]), .xchg_clus_0(xc0), .intr_req_0(irq[0]),
    .tas_pc_0(pc0), .op_1(op1), .first_cp_1(f1), .reg_sel_1(rs1), .sem_sel_1(ss1),
    .wdata_1(wd1), .monitor_1(mon[1]), .xchg_clus_load_1(xld[1]), .xchg_clus_1(xc1),
    .intr_req_1(irq[1]), .tas_pc_1(~pc0), .issue_hold(hold), .issue_done(done),
    .rdata_0(rd0), .rdata_1(rd1), .rvalid(rv), .deadlock_intr(dl), .discard_slots(disc),
    .restart_pc_0(rpc0), .restart_pc_1(), .semaphore_wait_flag(wsf),
    .cluster_select_0(cs0), .cluster_select_1(cs1), .cycle_counter(cnt));
  srs_cpu_model cpu0 (.clk(clk), .done(done[0]), .rv(rv[0]), .rd(rd0), .op(op0),
    .first_cp(f0), .reg_sel(rs0), .sem_sel(ss0), .wdata(wd0));
  srs_cpu_model cpu1 (.clk(clk), .done(done[1]), .rv(rv[1]), .rd(rd1), .op(op1),
    .first_cp(f1), .reg_sel(rs1), .sem_sel(ss1), .wdata(wd1));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [63:0] sem_exp(input logic [63:0] w, input logic [4:0] a,
      input logic [4:0] b);
    logic [63:0] e;
    e = w;
    e[63 - a] = 1'b0;
    e[63 - b] = 1'b1;
    return e;
  endfunction : sem_exp
  task automatic x0(input srs_pkg::srs_op_t op, input logic [4:0] sl, input logic [63:0] w);
    cpu0.run(op, 1'b1, sl, w, 4, h0, r0);
  endtask : x0
  task automatic x1(input srs_pkg::srs_op_t op, input logic [4:0] sl, input logic [63:0] w);
    cpu1.run(op, 1'b1, sl, w, 4, h1, r1);
  endtask : x1
  task automatic xclus(input logic [1:0] a, input logic [1:0] b);
    {xc0, xc1, xld} = {a, b, 2'b11};
    @(posedge clk);
    #1;
    xld = 2'b00;
    @(posedge clk);
    #1;
    chk("clus_sel", {60'h0, a, b}, {60'h0, cs0, cs1});
  endtask : xclus
  task automatic conclude();
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Whole run is a few hundred clocks; the 4000-clock limit leaves ample margin
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    resetn = 1'b0;
    {mon, xld, irq, xc0, xc1, pc0} = '0;
    v = $urandom(64006);
    repeat (8) @(posedge clk);
    #1;
    chk("rst_out", 64'h0, cnt | {cs0, cs1, dl, disc, wsf});
    resetn = 1'b1;
    c = cnt;
    repeat (10) @(posedge clk);
    #1;
    chk("cnt_step", c + 64'd10, cnt);
    v = {$urandom, $urandom};
    fork
      x0(srs_pkg::SRS_CNT_LOAD, 5'h0, v);
      x1(srs_pkg::SRS_CNT_READ, 5'h0, 64'h0);
    join
    chk("cnt_hold", 64'h0, 64'(h0 + h1));
    x1(srs_pkg::SRS_CNT_READ, 5'h0, 64'h0);
    chk("cnt_load", 64'h1, {63'h0, r1 - v < 64'd12});
    $display("Test counter done");
    xclus(2'h1, 2'h2);
    mon = 2'b10;
    x1(srs_pkg::SRS_CLUS_LOAD, 5'h0, 64'h1);
    mon = 2'b00;
    x1(srs_pkg::SRS_CLUS_LOAD, 5'h0, 64'h3);
    chk("clus_op", 64'h1, cs1);
    for (int k = 0; k < 6; k++) begin
      s = $urandom;
      v = {$urandom, $urandom};
      x0(srs_pkg::SRS_SA_WRITE, s, v);
      x1(srs_pkg::SRS_SA_READ, s, 64'h0);
      chk("sa_data", {40'h0, v[23:0]}, r1);
      x1(srs_pkg::SRS_SS_WRITE, s, v);
      x0(srs_pkg::SRS_SS_READ, s, 64'h0);
      chk("ss_data", v, r0);
    end
    xclus(2'h1, 2'h0);
    x1(srs_pkg::SRS_SS_WRITE, s, ~v);
    x1(srs_pkg::SRS_SS_READ, s, 64'h0);
    chk("clus0_rd", 64'h0, r1);
    x0(srs_pkg::SRS_SS_READ, s, 64'h0);
    chk("clus0_wr", v, r0);
    $display("Test shared registers done");
    for (int k = 0; k < 8; k++) begin
      o = k < 4 ? srs_pkg::SRS_SA_READ : srs_pkg::SRS_SA_WRITE;
      fork
        cpu0.run(o, k[0], 5'h1, v, 4, h0, r0);
        cpu1.run(o, k[1], 5'h2, v, 4, h1, r1);
      join
      chk("hold_pair", k[1] ? 64'h1 : 64'h100000000, {32'(h0), 32'(h1)});
    end
    fork
      x0(srs_pkg::SRS_SS_WRITE, 5'h3, v);
      begin
        repeat (3) @(posedge clk);
        #1;
        x1(srs_pkg::SRS_SS_READ, 5'h3, 64'h0);
      end
    join
    chk("rd_after_wr", 64'h1, 64'(h1));
    $display("Test conflicts done");
    xclus(2'h3, 2'h3);
    for (int k = 0; k < 4; k++) begin
      {s, t} = k == 0 ? 10'h01f : 10'($urandom);
      v = {$urandom, 32'h0};
      x0(srs_pkg::SRS_SEM_WRITE, 5'h0, v);
      x1(srs_pkg::SRS_SEM_CLR, s, 64'h0);
      x0(srs_pkg::SRS_SEM_SET, t, 64'h0);
      x1(srs_pkg::SRS_SEM_READ, 5'h0, 64'h0);
      chk("sem_word", sem_exp(v, s, t), r1);
    end
    xclus(2'h1, 2'h1);
    x1(srs_pkg::SRS_SS_WRITE, 5'h7, v);
    fork
      x0(srs_pkg::SRS_SS_WRITE, 5'h6, ~v);
      x1(srs_pkg::SRS_SS_READ, 5'h7, 64'h0);
    join
    chk("rw_pair_rd", v, r1);
    x1(srs_pkg::SRS_SS_READ, 5'h6, 64'h0);
    chk("rw_pair_wr", ~v, r1);
    x0(srs_pkg::SRS_SEM_WRITE, 5'h0, 64'h0);
    fork
      cpu0.run(srs_pkg::SRS_SEM_TAS, 1'b1, 5'h9, 64'h0, 6, h0, r0);
      cpu1.run(srs_pkg::SRS_SEM_TAS, 1'b1, 5'h9, 64'h0, 6, h1, r1);
    join
    chk("tas_race", 64'hffffffff, {32'(h0), 32'(h1)});
    x1(srs_pkg::SRS_SEM_READ, 5'h0, 64'h0);
    chk("tas_bit", 64'h0040000000000000, r1);
    fork
      cpu1.run(srs_pkg::SRS_SEM_TAS, 1'b1, 5'h9, 64'h0, 20, h1, r1);
      begin
        repeat (5) @(posedge clk);
        #1;
        x0(srs_pkg::SRS_SEM_CLR, 5'h9, 64'h0);
      end
    join
    chk("tas_wake", 64'h1, {63'h0, h1 > 4 && h1 < 8});
    fork
      x0(srs_pkg::SRS_SEM_TAS, 5'h9, 64'h0);
      x1(srs_pkg::SRS_SEM_TAS, 5'h9, 64'h0);
      begin
        repeat (3) @(posedge clk);
        #1;
        chk("dl_both", 64'h3, dl);
      end
    join
    xclus(2'h1, 2'h0);
    pc0 = $urandom;
    fork
      cpu0.run(srs_pkg::SRS_SEM_TAS, 1'b1, 5'h9, 64'h0, 12, h0, r0);
      cpu1.run(srs_pkg::SRS_SEM_TAS, 1'b1, 5'h9, 64'h0, 3, h1, r1);
      begin
        repeat (3) @(posedge clk);
        #1;
        chk("dl_one", 64'h1, dl);
        irq[0] = 1'b1;
        for (int i = 0; i < 6 && disc[0] !== 1'b1; i++) begin
          @(posedge clk);
          #1;
        end
        chk("restart", {pc0, 2'b11}, {rpc0, disc[0], wsf[0]});
        irq[0] = 1'b0;
      end
    join
    $display("Test semaphores done");
    conclude();
  end
endmodule : srs_top_tb
